// >>> logic/icdiag_access.sv
// Diagnostic register access into the instruction cache data and tag arrays
//
// Summary of operation
// - Data mode: 32-bit chunk, halves separately protected
// - Tag mode: tag in 31:12, unused bits zero
// - LRU bits 6:4, shared by whole set
// - LRU bits pick way pair, then way
// - Bit 0 in tag mode is line valid
// - Layout follows currently selected array
// - Parity build: bit1 upper, bit0 lower/tag
// - Code build: 9:5 upper, 4:0 lower/tag
// - Hardware makes and checks check bits normally
// - Access only in debug mode, else illegal
// - Trigger read loads both holding registers
// - Trigger write-one stores holding registers
// - Trigger bit reads zero, resets zero
// - Four ways, four 16-byte banks per line
// - Index bits 3:2 choose chunk in bank
// - Array select picks data or tag array
// - Reserved bits zero, fields return legal values
// - Way 21:20, index 15:2, tag ignores 5:2
`timescale 1ns/100ps
module icdiag_access
  import icdiag_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Register access port
  input  wire logic            csr_en,
  input  wire logic            csr_we,
  input  wire logic [11:0]     csr_addr,
  input  wire logic [31:0]     csr_wdata,
  input  wire logic            debug_mode,
  output logic [31:0]          csr_rdata,
  output logic                 csr_illegal,
  // Selection register contents
  input  wire icdiag_sel_type  sel,
  // Cache array port
  output icdiag_req_type       arr_req,
  input  wire logic            arr_ack,
  input  wire icdiag_resp_type arr_resp,
  // Normal fill and fetch protection
  input  wire logic [31:0]     fill_data,
  input  wire logic            fill_tag_sel,
  output logic [CHECK_W-1:0]   fill_check,
  input  wire logic [31:0]     fetch_data,
  input  wire logic [CHECK_W-1:0] fetch_check,
  input  wire logic            fetch_tag_sel,
  input  wire logic            fetch_valid,
  output logic                 fetch_err
);

  // Holding registers and sequencer
  logic [31:0]          data_low_reg;   // First holding register
  logic [CHECK_W-1:0]   check_reg;      // Second holding register
  icdiag_state_type     state_reg;      // Access sequencer
  logic                 wait_tag_reg;   // Array kind of pending read
  logic [31:0]          csr_rdata_reg;  // Registered read answer
  logic                 csr_illegal_reg;// Registered exception pulse
  icdiag_req_type       arr_req_reg;    // Registered array request
  logic [CHECK_W-1:0]   fill_check_reg; // Registered fill check bits
  logic                 fetch_err_reg;  // Registered fetch error

  // Decoded access
  logic                 hit;            // One of our three addresses
  logic                 allowed;        // Hit in debug mode
  logic                 trig_rd;        // Read of the trigger register
  logic                 trig_wr_one;    // Write-one to the trigger bit
  logic [31:0]          data_view;      // First register as software sees it
  logic [CHECK_W-1:0]   check_mask;     // Legal bits of the second register
  logic [CHECK_W-1:0]   check_view;     // Second register as software sees it
  logic [INDEX_W-1:0]   eff_index;      // Index sent to the arrays
  logic [CHECK_W-1:0]   fill_gen;       // Generated bits for fills
  logic [CHECK_W-1:0]   fetch_gen;      // Regenerated bits for fetches
  logic [CHECK_W-1:0]   fetch_mask;     // Legal bits for the fetched kind

  // Address decode and privilege gate
  assign hit         = csr_en && (csr_addr == ADDR_DATA_LOW ||
                                  csr_addr == ADDR_CHECK ||
                                  csr_addr == ADDR_TRIGGER);
  assign allowed     = hit && debug_mode;
  assign trig_rd     = allowed && !csr_we &&
                       csr_addr == ADDR_TRIGGER;
  assign trig_wr_one = allowed && csr_we && csr_addr == ADDR_TRIGGER &&
                       csr_wdata[TRIGGER_BIT];

  // Layout switches with the selected array
  always_comb begin
    if (sel.array) begin
      data_view  = data_low_reg & TAG_VIEW_MASK;
      check_mask = ECC_BUILD ? ECC_TAG_MASK : PAR_TAG_MASK;
    end else begin
      data_view  = data_low_reg;
      check_mask = ECC_BUILD ? ECC_DATA_MASK : PAR_DATA_MASK;
    end
  end

  assign check_view = check_reg & check_mask;

  // Tag accesses address a whole line, so chunk bits are dropped
  assign eff_index = sel.array ? (sel.index & ~IDX_CHUNK_MASK)
                               : sel.index;

  // Sequencer: one array read outstanding at a time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      wait_tag_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Launch the read and remember which layout it returns
          if (trig_rd) begin
            state_reg    <= ST_WAIT;
            wait_tag_reg <= sel.array;
          end
        end
        ST_WAIT: begin
          // Arrays answer with the selected contents
          if (arr_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Array request: one-cycle pulse per read or write-one trigger taken while the sequencer is idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_req_reg <= '0;
    end else begin
      arr_req_reg.valid <= 1'b0;
      if (state_reg == ST_IDLE && (trig_rd || trig_wr_one)) begin
        // Way picks one of four; LRU in the word is set-wide
        arr_req_reg.valid   <= 1'b1;
        arr_req_reg.we      <= trig_wr_one;
        arr_req_reg.tag_sel <= sel.array;
        arr_req_reg.way     <= sel.way;
        arr_req_reg.index   <= eff_index;
        arr_req_reg.wdata   <= data_view;
        arr_req_reg.wcheck  <= check_view;
      end
    end
  end

  // First holding register: software write or array read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_low_reg <= '0;
    end else if (state_reg == ST_WAIT && arr_ack) begin
      // Read data arrives in the layout of the pending array
      data_low_reg <= wait_tag_reg ? (arr_resp.data & TAG_VIEW_MASK)
                                   : arr_resp.data;
    end else if (allowed && csr_we && csr_addr == ADDR_DATA_LOW) begin
      data_low_reg <= csr_wdata;
    end
  end

  // Second holding register: only check bits legal for the data array stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_reg <= '0;
    end else if (state_reg == ST_WAIT && arr_ack) begin
      check_reg <= arr_resp.check &
                   (wait_tag_reg ? (ECC_BUILD ? ECC_TAG_MASK : PAR_TAG_MASK)
                                 : (ECC_BUILD ? ECC_DATA_MASK
                                              : PAR_DATA_MASK));
    end else if (allowed && csr_we && csr_addr == ADDR_CHECK) begin
      check_reg <= csr_wdata[CHECK_W-1:0] &
                   (ECC_BUILD ? ECC_DATA_MASK : PAR_DATA_MASK);
    end
  end

  // Read answer and exception, one cycle after the access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_rdata_reg   <= '0;
      csr_illegal_reg <= 1'b0;
    end else begin
      csr_illegal_reg <= hit && !debug_mode;
      csr_rdata_reg   <= '0;
      if (allowed && !csr_we) begin
        case (csr_addr)
          ADDR_DATA_LOW: begin
            csr_rdata_reg <= data_view;
          end
          ADDR_CHECK: begin
            csr_rdata_reg <= {22'h000000, check_view};
          end
          default: begin
            csr_rdata_reg <= '0;
          end
        endcase
      end
    end
  end

  // Normal-path check bit generation and checking
  icdiag_check_gen u_fill_gen (
    .data    (fill_data),
    .tag_sel (fill_tag_sel),
    .check   (fill_gen)
  );

  icdiag_check_gen u_fetch_gen (
    .data    (fetch_data),
    .tag_sel (fetch_tag_sel),
    .check   (fetch_gen)
  );

  assign fetch_mask = fetch_tag_sel
                    ? (ECC_BUILD ? ECC_TAG_MASK : PAR_TAG_MASK)
                    : (ECC_BUILD ? ECC_DATA_MASK : PAR_DATA_MASK);

  // Register fill bits and fetch mismatch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_check_reg <= '0;
      fetch_err_reg  <= 1'b0;
    end else begin
      fill_check_reg <= fill_gen;
      fetch_err_reg  <= fetch_valid &&
                        ((fetch_gen ^ fetch_check) & fetch_mask) != '0;
    end
  end

  // Outputs straight from flip-flops
  assign csr_rdata   = csr_rdata_reg;
  assign csr_illegal = csr_illegal_reg;
  assign arr_req     = arr_req_reg;
  assign fill_check  = fill_check_reg;
  assign fetch_err   = fetch_err_reg;

  // Checks next to the logic they guard
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_illegal_out_debug: assert property (
    hit && !debug_mode |=> csr_illegal && !arr_req.valid)
    else $error("Access outside debug mode not refused");

  a_trig_reads_zero: assert property (
    allowed && !csr_we && csr_addr == ADDR_TRIGGER |=> csr_rdata == '0)
    else $error("Trigger register did not read zero");

  a_read_launch: assert property (
    trig_rd && state_reg == ST_IDLE |=> arr_req.valid && !arr_req.we
      ##1 state_reg == ST_WAIT || $past(arr_ack))
    else $error("Trigger read did not launch an array read");

  a_write_one_copy: assert property (
    trig_wr_one && state_reg == ST_IDLE |=>
      arr_req.valid && arr_req.we && arr_req.wdata == $past(data_view)
      && arr_req.wcheck == $past(check_view))
    else $error("Write-one did not copy holding registers");

  a_write_zero_idle: assert property (
    allowed && csr_we && csr_addr == ADDR_TRIGGER &&
      !csr_wdata[TRIGGER_BIT] |=> !arr_req.valid)
    else $error("Write-zero touched the array");

  a_ack_loads_data: assert property (
    state_reg == ST_WAIT && arr_ack && !wait_tag_reg |=>
      data_low_reg == $past(arr_resp.data) && state_reg == ST_IDLE)
    else $error("Array read data not loaded");

  a_tag_index_clear: assert property (
    arr_req.valid && arr_req.tag_sel |->
      (arr_req.index & IDX_CHUNK_MASK) == '0)
    else $error("Tag access kept chunk index bits");

  a_check_legal: assert property (
    (check_reg & ~(ECC_BUILD ? ECC_DATA_MASK : PAR_DATA_MASK)) == '0)
    else $error("Illegal check bits stored");

  a_tag_view_zero: assert property (
    allowed && !csr_we && csr_addr == ADDR_DATA_LOW && sel.array |=>
      (csr_rdata & ~TAG_VIEW_MASK) == '0)
    else $error("Unused tag-mode bits did not read zero");

endmodule

// >>> logic/icdiag_check_gen.sv
// Parity or correction code generator for one instruction word or one tag
`timescale 1ns/100ps
module icdiag_check_gen
  import icdiag_pkg::*;
(
  // Protected word and array kind
  input  wire logic [31:0]        data,
  input  wire logic               tag_sel,
  // Generated check bits
  output logic [CHECK_W-1:0]      check
);

  // Single-error code over the low n bits, power-of-two slots skipped
  function automatic logic [CODE_W-1:0] code5(input logic [31:0] d,
                                              input int n);
    logic [CODE_W-1:0] c;
    int                pos;
    c   = '0;
    pos = 1;
    for (int i = 0; i < n; i++) begin
      pos = pos + 1;
      while ((pos & (pos - 1)) == 0) begin
        pos = pos + 1;
      end
      for (int b = 0; b < CODE_W; b++) begin
        if (pos[b]) begin
          c[b] = c[b] ^ d[i];
        end
      end
    end
    return c;
  endfunction

  logic [31:0] tag_word;  // Tag right-justified

  assign tag_word = (data & TAG_FIELD_MASK) >> TAG_LSB;

  // Select layout by build and by array
  always_comb begin
    check = '0;
    if (ECC_BUILD) begin
      if (tag_sel) begin
        check[CODE_W-1:0] = code5(tag_word, TAG_BITS);
      end else begin
        check[CODE_W-1:0]        = code5({16'h0000, data[15:0]}, HALF_W);
        check[CHECK_W-1:CODE_W]  = code5({16'h0000, data[31:16]}, HALF_W);
      end
    end else begin
      if (tag_sel) begin
        check[0] = ^tag_word;
      end else begin
        check[0] = ^data[15:0];
        check[1] = ^data[31:16];
      end
    end
  end

endmodule

// >>> logic/icdiag_pkg.sv
// Package: constants and carrier types for the cache diagnostic access path
package icdiag_pkg;

  // Register addresses in the control/status space
  localparam logic [11:0] ADDR_DATA_LOW  = 12'h7c9;
  localparam logic [11:0] ADDR_CHECK     = 12'h7ca;
  localparam logic [11:0] ADDR_TRIGGER   = 12'h7cb;

  // Build option: 1 selects the code build, 0 the parity build
  localparam logic        ECC_BUILD      = 1'b1;

  // Cache geometry
  localparam int          ICACHE_KB      = 16;
  localparam int          TAG_LSB        = 12;
  localparam int          TAG_BITS       = 20 - $clog2(ICACHE_KB / 16);
  localparam int          INDEX_W        = 14;
  localparam int          HALF_W         = 16;
  localparam int          CODE_W         = 5;
  localparam int          CHECK_W        = 10;

  // First holding register layout in tag/status mode
  localparam logic [31:0] TAG_FIELD_MASK =
    (32'hffff_ffff >> (32 - TAG_BITS)) << TAG_LSB;
  localparam logic [31:0] LRU_MASK       = 32'h0000_0070;
  localparam logic [31:0] VALID_MASK     = 32'h0000_0001;
  localparam logic [31:0] TAG_VIEW_MASK  =
    TAG_FIELD_MASK | LRU_MASK | VALID_MASK;

  // Second holding register legal bits per build and array
  localparam logic [9:0]  PAR_DATA_MASK  = 10'h003;
  localparam logic [9:0]  PAR_TAG_MASK   = 10'h001;
  localparam logic [9:0]  ECC_DATA_MASK  = 10'h3ff;
  localparam logic [9:0]  ECC_TAG_MASK   = 10'h01f;

  // Trigger bit and index bits ignored for tag/status accesses
  localparam int          TRIGGER_BIT    = 0;
  localparam logic [13:0] IDX_CHUNK_MASK = 14'h000f;

  // Location chosen by the selection register
  typedef struct packed {
    logic              array;
    logic [1:0]        way;
    logic [INDEX_W-1:0] index;
  } icdiag_sel_type;

  // Request towards the cache arrays
  typedef struct packed {
    logic               valid;
    logic               we;
    logic               tag_sel;
    logic [1:0]         way;
    logic [INDEX_W-1:0] index;
    logic [31:0]        wdata;
    logic [CHECK_W-1:0] wcheck;
  } icdiag_req_type;

  // Contents returned by the cache arrays
  typedef struct packed {
    logic [31:0]        data;
    logic [CHECK_W-1:0] check;
  } icdiag_resp_type;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } icdiag_state_type;

endpackage

// >>> tb/icdiag_access_test.sv
// Self-checking testbench for the cache diagnostic access path
`timescale 1ns/100ps
module icdiag_access_test;
  import icdiag_pkg::*;
  logic            core_clk, rst_n, csr_en, csr_we, debug_mode;
  logic [11:0]     csr_addr;
  logic [31:0]     csr_wdata, csr_rdata, fill_data, rd;
  logic            csr_illegal, arr_ack, fetch_valid, fetch_err, ill;
  logic            tag_k;
  logic [9:0]      fill_check, fetch_check, ex;
  icdiag_sel_type  sel;
  icdiag_req_type  arr_req;
  icdiag_resp_type arr_resp;
  int              n_errors, checked;

  icdiag_access i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .csr_en(csr_en), .csr_we(csr_we), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .debug_mode(debug_mode),
    .csr_rdata(csr_rdata), .csr_illegal(csr_illegal), .sel(sel),
    .arr_req(arr_req), .arr_ack(arr_ack), .arr_resp(arr_resp),
    .fill_data(fill_data), .fill_tag_sel(tag_k),
    .fill_check(fill_check), .fetch_data(fill_data),
    .fetch_check(fetch_check), .fetch_tag_sel(tag_k),
    .fetch_valid(fetch_valid), .fetch_err(fetch_err));
  icdiag_array_model i_model (.core_clk(core_clk), .rst_n(rst_n),
    .arr_req(arr_req), .arr_ack(arr_ack), .arr_resp(arr_resp));

  // Single-error code over n bits, positions skip powers of two
  function automatic logic [4:0] ham(input logic [19:0] v,
                                     input int n);
    int p;
    logic [4:0] c;
    c = '0;
    p = 3;
    for (int i = 0; i < n; i++) begin
      if ((p & (p - 1)) == 0) p++;
      if (v[i]) c ^= p[4:0];
      p++;
    end
    return c;
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One register access, answer taken the cycle after
  task automatic acc(input logic we, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    csr_en <= 1'b1;
    csr_we <= we;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge core_clk);
    csr_en <= 1'b0;
    #1;
    rd = csr_rdata;
    ill = csr_illegal;
  endtask

  // Trigger read, then wait for the array answer to land
  task automatic go_read;
    int i;
    acc(1'b0, ADDR_TRIGGER, 32'h0);
    chk("trigger read", rd, 32'h0);
    for (i = 0; i < 20 && arr_ack !== 1'b1; i++) @(posedge core_clk) #1;
    if (i == 20) begin
      n_errors++;
      complete_run();
    end
    @(posedge core_clk);
  endtask

  // Reset values; the trigger read must land before later writes
  task automatic t_reset;
    for (int a = 0; a < 2; a++) begin
      acc(1'b0, 12'(ADDR_DATA_LOW + a), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    go_read();
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("empty location", rd, 32'h0);
    $display("test reset done");
  endtask

  // Data array round trip and layout switch
  task automatic t_data;
    sel <= {1'b0, 2'd1, 14'h0007};
    acc(1'b1, ADDR_DATA_LOW, 32'h1234_abcd);
    acc(1'b1, ADDR_CHECK, 32'hffff_fea5);
    acc(1'b0, ADDR_CHECK, 32'h0);
    chk("check mask", rd, 32'h2a5);
    acc(1'b1, ADDR_TRIGGER, 32'h1);
    acc(1'b1, ADDR_DATA_LOW, 32'h0);
    acc(1'b1, ADDR_CHECK, 32'h0);
    go_read();
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("data word", rd, 32'h1234_abcd);
    acc(1'b0, ADDR_CHECK, 32'h0);
    chk("data check", rd, 32'h2a5);
    sel <= {1'b1, 2'd1, 14'h0007};
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("tag view", rd, 32'h1234_abcd & TAG_VIEW_MASK);
    acc(1'b0, ADDR_CHECK, 32'h0);
    chk("tag check view", rd, 32'h5);
    $display("test data done");
  endtask

  // Tag array, ignored index bits, shared LRU, write of zero
  task automatic t_tag;
    int w;
    sel <= {1'b1, 2'd2, 14'h0035};
    acc(1'b1, ADDR_DATA_LOW, 32'hffff_ffff);
    acc(1'b1, ADDR_CHECK, 32'hffff_ffff);
    acc(1'b1, ADDR_TRIGGER, 32'h1);
    sel <= {1'b1, 2'd2, 14'h0030};
    go_read();
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("tag word", rd, TAG_VIEW_MASK);
    acc(1'b0, ADDR_CHECK, 32'h0);
    chk("tag code", rd, 32'h1f);
    sel <= {1'b1, 2'd0, 14'h0030};
    go_read();
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("lru other way", rd, 32'h70);
    w = i_model.writes;
    acc(1'b1, ADDR_TRIGGER, 32'hffff_fffe);
    repeat (3) @(posedge core_clk);
    chk("write zero", w, i_model.writes);
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("holding kept", rd, 32'h70);
    $display("test tag done");
  endtask

  // Outside debug mode, and an unmapped address
  task automatic t_illegal;
    debug_mode <= 1'b0;
    acc(1'b1, ADDR_DATA_LOW, 32'h5555_5555);
    chk("illegal write", {31'h0, ill}, 32'h1);
    acc(1'b0, ADDR_TRIGGER, 32'h0);
    chk("illegal read", {ill, rd[30:0]}, 32'h8000_0000);
    debug_mode <= 1'b1;
    acc(1'b0, ADDR_DATA_LOW, 32'h0);
    chk("no change", {ill, rd[30:0]}, 32'h70);
    acc(1'b0, 12'h7cc, 32'h0);
    chk("unmapped", {ill, rd[30:0]}, 32'h0);
    $display("test illegal done");
  endtask

  // Normal fill code generation and fetch checking
  task automatic t_code;
    ex = {ham(20'h1234, 16), ham(20'habcd, 16)};
    @(posedge core_clk);
    fill_data <= 32'h1234_abcd;
    fetch_check <= ex;
    @(posedge core_clk) #1;
    chk("fill code", {22'h0, fill_check}, {22'h0, ex});
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk);
      fetch_check <= ex ^ 10'(b);
      fetch_valid <= 1'b1;
      @(posedge core_clk);
      fetch_valid <= 1'b0;
      #1;
      chk("fetch error", {31'h0, fetch_err}, 32'(b));
    end
    // Tag kind: upper code bits lie outside the tag code, so no error
    @(posedge core_clk);
    tag_k <= 1'b1;
    fill_data <= 32'habcd_e123;
    fetch_check <= {5'h1f, ham(20'habcde, 20)};
    fetch_valid <= 1'b1;
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    #1;
    chk("tag fill", {22'h0, fill_check}, {27'h0, ham(20'habcde, 20)});
    chk("tag fetch", {31'h0, fetch_err}, 32'h0);
    $display("test code done");
  endtask

  // Core clock, 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Main sequence
  initial begin
    {rst_n, csr_en, csr_we, fetch_valid, tag_k} = '0;
    {csr_addr, csr_wdata, fill_data, fetch_check} = '0;
    debug_mode = 1'b1;
    sel = '0;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_data();
    t_tag();
    t_illegal();
    t_code();
    complete_run();
  end
endmodule

// >>> tb/icdiag_array_model.sv
// Behavioural model of the cache arrays behind the diagnostic path
`timescale 1ns/100ps
module icdiag_array_model
  import icdiag_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // Array port
  input  wire icdiag_req_type  arr_req,
  output logic                 arr_ack,
  output icdiag_resp_type      arr_resp
);
  icdiag_resp_type mem [int];  // Stored words by location
  logic [2:0]      lru [int];  // Set-wide pseudo-LRU
  icdiag_req_type  pend;       // Pending read
  icdiag_resp_type r;          // Next answer bus value
  logic            busy;       // Read outstanding
  int              wait_cnt;   // Cycles left before answer
  int              delay;      // Next answer delay, 0..2
  int              writes;     // Array writes seen
  int              k;          // Location key
  // Store writes, answer reads slowly or promptly
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_ack <= 1'b0;
      arr_resp <= '0;
      busy <= 1'b0;
      delay <= 0;
      writes <= 0;
    end else begin
      arr_ack <= 1'b0;
      // Idle answer bus never holds the last value
      r = ~arr_resp;
      k = {arr_req.tag_sel, arr_req.way, arr_req.index};
      if (arr_req.valid && arr_req.we) begin
        mem[k] = '{data: arr_req.wdata, check: arr_req.wcheck};
        if (arr_req.tag_sel) begin
          lru[arr_req.index] = arr_req.wdata[6:4];
        end
        writes <= writes + 1;
      end
      if (arr_req.valid && !arr_req.we) begin
        busy <= 1'b1;
        pend <= arr_req;
        wait_cnt <= delay;
        delay <= (delay + 1) % 3;
      end else if (busy && wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else if (busy) begin
        k = {pend.tag_sel, pend.way, pend.index};
        busy <= 1'b0;
        arr_ack <= 1'b1;
        r = mem.exists(k) ? mem[k] : '0;
        if (pend.tag_sel && lru.exists(pend.index)) begin
          r.data[6:4] = lru[pend.index];
        end
      end
      arr_resp <= r;
    end
  end
endmodule
